// ---- acr_pkg.sv ----
// Constants, field positions and carrier types of the audio control bank
// Function
// - Bits 31 and 27 halve DAC, ADC paths
// - Field 29:28 selects de-emphasis rate or none
// - Bit 25 keeps ADC DC offset when bit 17 is set, bit 25 clear clears it
// - Bits 22, 21:20 invert ADC, microphone polarity
// - Bit 17 clear keeps ADC high-pass active
// - Field 13:12 selects microphone boost level
// - Field 10:8 caps PGA gain, six dB steps
// - Bit 7 commits latched input volume
// - Bit 5 defers gain change to zero crossing
// - Five-bit input volume, 1.5 dB steps
// - Line-out control enable low, gain commit high
// - Line-out codes 63 and below mute output
// - Bit 31 picks biphase or serial, never both
// - Routing bits steer serial and playback data
// - Field 26:24 selects record sample rate
// - Field 15:12 selects playback rate, clock family
// - Bit 7 inverts serial bit clock
// - Bit 6 selects serial clock master
// - Bit 5 swaps channels, bit 4 inverts frame
// - Field 3:2 selects audio word length
// - Field 1:0 selects serial data format
package acr_pkg;
    localparam int ACR_ADDR_W = 12;
    localparam logic [ACR_ADDR_W-1:0] ACR_OFS_INPUT = 12'h000;
    localparam logic [ACR_ADDR_W-1:0] ACR_OFS_LINEOUT = 12'h004;
    localparam logic [ACR_ADDR_W-1:0] ACR_OFS_PATH = 12'h008;
    localparam logic [31:0] ACR_RST_INPUT = 32'h40008F57;
    localparam logic [31:0] ACR_RST_LINEOUT = 32'h3CF93CF9;
    localparam logic [31:0] ACR_RST_PATH = 32'h0001000A;
    // Input gain register fields
    localparam int ACR_IN_PLAY_HALVE = 31, ACR_IN_SOFT_MUTE = 30;
    localparam int ACR_IN_DEEMPH = 28, ACR_IN_REC_HALVE = 27;
    localparam int ACR_IN_DC_STORE = 25, ACR_IN_ADC_POL = 22;
    localparam int ACR_IN_DMIC_POL = 20, ACR_IN_HPF_OFF = 17;
    localparam int ACR_IN_BOOST = 12, ACR_IN_ANA_MUTE = 11;
    localparam int ACR_IN_MAXGAIN = 8, ACR_IN_COMMIT = 7;
    localparam int ACR_IN_LMUTE = 6, ACR_IN_ZC_EN = 5, ACR_IN_VOL = 0;
    localparam logic [4:0] ACR_VOL_ZERO_DB = 5'h17;
    // Line-out register fields
    localparam int ACR_LO_CTRL_DIS = 15, ACR_LO_COMMIT = 14;
    localparam int ACR_LO_RIGHT = 7, ACR_LO_LEFT = 0;
    // Path-control register fields
    localparam int ACR_PC_BIPHASE = 31, ACR_PC_USB_SP = 30;
    localparam int ACR_PC_USB_PB = 29, ACR_PC_REC_RATE = 24;
    localparam int ACR_PC_PB_RATE = 12, ACR_PC_SP_SRC = 9;
    localparam int ACR_PC_PB_SRC = 8, ACR_PC_BCLK_INV = 7;
    localparam int ACR_PC_MASTER = 6, ACR_PC_LR_SWAP = 5;
    localparam int ACR_PC_LRCLK_INV = 4, ACR_PC_WLEN = 2, ACR_PC_FMT = 0;

    typedef struct packed {
        logic record_halve;
        logic dc_hold;
        logic dc_clear;
        logic adc_pol_inv;
        logic [1:0] dmic_pol_inv;
        logic hpf_enable;
        logic [4:0] mic_boost_db;
        logic signed [6:0] pga_max_db;
        logic analog_mute;
        logic [2:0] record_rate_sel;
    } acr_record_type;

    typedef struct packed {
        logic playback_halve;
        logic soft_mute;
        logic [1:0] deemph_sel;
        logic [3:0] playback_rate_sel;
        logic mclk_22m;
    } acr_playback_type;

    typedef struct packed {
        logic biphase_en;
        logic serial_en;
        logic usb_to_serial_port;
        logic usb_to_playback;
        logic serial_port_source_sel;
        logic playback_source_sel;
        logic bclk_inv;
        logic clock_master_sel;
        logic lr_swap;
        logic lrclk_inv;
        logic [5:0] word_bits;
        logic [1:0] interface_type_field;
    } acr_port_type;

    typedef struct packed {
        logic signed [7:0] gain_half_db;
        logic left_mute;
        logic pending;
    } acr_input_gain_type;

    typedef struct packed {
        logic gain_ctrl_en;
        logic lineout_gain_commit;
        logic [6:0] lineout_left_level;
        logic [6:0] lineout_right_level;
        logic left_mute;
        logic right_mute;
    } acr_lineout_type;
endpackage

// ---- acr_vol_commit.sv ----
// Intermediate latch and zero-cross commit for the left input volume
`timescale 1ns/1ns
`default_nettype none
module acr_vol_commit (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Register write side
    input wire logic wr_i,
    input wire logic [4:0] vol_i,
    input wire logic mute_i,
    input wire logic commit_i,
    input wire logic zc_en_i,
    // Analog side
    input wire logic zero_cross_i,
    output logic [4:0] vol_o,
    output logic mute_o,
    output logic pending_o
);
    import acr_pkg::*;
    logic [4:0] staged_vol_reg;
    logic staged_mute_reg;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            staged_vol_reg <= ACR_RST_INPUT[ACR_IN_VOL +: 5];
            staged_mute_reg <= ACR_RST_INPUT[ACR_IN_LMUTE];
        end else if (wr_i) begin
            staged_vol_reg <= vol_i;
            staged_mute_reg <= mute_i;
        end
    end

    // A zero-cross commit waits in pending; a new zero-cross commit write restarts the wait, any other write ends it
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            vol_o <= ACR_RST_INPUT[ACR_IN_VOL +: 5];
            mute_o <= ACR_RST_INPUT[ACR_IN_LMUTE];
            pending_o <= 1'b0;
        end else if (wr_i && commit_i && !zc_en_i) begin
            vol_o <= vol_i;
            mute_o <= mute_i;
            pending_o <= 1'b0;
        end else if (wr_i) begin
            pending_o <= commit_i;
        end else if (pending_o && zero_cross_i) begin
            vol_o <= staged_vol_reg;
            mute_o <= staged_mute_reg;
            pending_o <= 1'b0;
        end
    end
endmodule // acr_vol_commit
`default_nettype wire

// ---- acr_regs.sv ----
// Audio codec control register bank on the peripheral bus
`timescale 1ns/1ns
`default_nettype none
module acr_regs (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Peripheral bus slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [acr_pkg::ACR_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Analog record path
    input wire logic adc_zero_cross_i,
    // Decoded configuration
    output acr_pkg::acr_record_type record_cfg_o,
    output acr_pkg::acr_playback_type playback_cfg_o,
    output acr_pkg::acr_port_type port_cfg_o,
    output acr_pkg::acr_input_gain_type input_gain_o,
    output acr_pkg::acr_lineout_type lineout_o,
    output logic digital_reset_o
);
    import acr_pkg::*;

    logic [31:0] input_gain_config_reg;
    logic [31:0] lineout_gain_config_reg;
    logic [31:0] audio_path_control_reg;
    logic setup_phase;
    logic wr_access;
    logic wr_input;
    logic wr_path;
    logic [4:0] applied_vol;
    logic applied_mute;
    logic vol_pending;

    function automatic logic [1:0] acr_decode(
        input logic [ACR_ADDR_W-1:0] addr);
        logic [1:0] idx;
        idx = 2'h3;
        case (addr)
            ACR_OFS_INPUT: idx = 2'h0;
            ACR_OFS_LINEOUT: idx = 2'h1;
            ACR_OFS_PATH: idx = 2'h2;
            default: idx = 2'h3;
        endcase
        return idx;
    endfunction

    function automatic logic signed [7:0] acr_vol_half_db(
        input logic [4:0] code);
        logic signed [7:0] d;
        d = $signed({3'h0, code}) - $signed({3'h0, ACR_VOL_ZERO_DB});
        return 8'(d + d + d);
    endfunction

    function automatic logic [4:0] acr_boost_db(input logic [1:0] code);
        logic [4:0] db;
        case (code)
            2'h1: db = 5'h0D;
            2'h2: db = 5'h14;
            2'h3: db = 5'h1D;
            default: db = 5'h00;
        endcase
        return db;
    endfunction

    function automatic logic acr_is_22m(input logic [3:0] code);
        logic fam;
        case (code)
            4'hB, 4'hC, 4'hD, 4'h8, 4'hF, 4'hA: fam = 1'b1;
            default: fam = 1'b0;
        endcase
        return fam;
    endfunction

    function automatic logic [5:0] acr_word_bits(input logic [1:0] code);
        logic [5:0] bits;
        case (code)
            2'h3: bits = 6'h20;
            2'h2: bits = 6'h18;
            2'h1: bits = 6'h14;
            default: bits = 6'h10;
        endcase
        return bits;
    endfunction

    assign setup_phase = psel_i && !penable_i;
    assign wr_access = psel_i && penable_i && pwrite_i;
    assign wr_input = wr_access && (acr_decode(paddr_i) == 2'h0);
    assign wr_path = wr_access && (acr_decode(paddr_i) == 2'h2);

    // Zero wait states: read data is set up during the setup phase
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            prdata_o <= 32'h00000000;
            pslverr_o <= 1'b0;
            pready_o <= 1'b0;
        end else begin
            pready_o <= setup_phase;
            pslverr_o <= setup_phase && (acr_decode(paddr_i) == 2'h3);
            if (setup_phase && !pwrite_i) begin
                case (acr_decode(paddr_i))
                    2'h0: prdata_o <= input_gain_config_reg;
                    2'h1: prdata_o <= lineout_gain_config_reg;
                    2'h2: prdata_o <= audio_path_control_reg;
                    default: prdata_o <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            input_gain_config_reg <= ACR_RST_INPUT;
        end else if (wr_input) begin
            input_gain_config_reg <= pwdata_i;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            lineout_gain_config_reg <= ACR_RST_LINEOUT;
        end else if (wr_access && (acr_decode(paddr_i) == 2'h1)) begin
            lineout_gain_config_reg <= pwdata_i;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            audio_path_control_reg <= ACR_RST_PATH;
        end else if (wr_path) begin
            audio_path_control_reg <= pwdata_i;
        end
    end

    // Pulse lands together with the new field values on the outputs
    logic wr_path_d;
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_path_d <= 1'b0;
            digital_reset_o <= 1'b0;
        end else begin
            wr_path_d <= wr_path;
            digital_reset_o <= wr_path_d;
        end
    end

    acr_vol_commit u_vol_commit (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .wr_i(wr_input),
        .vol_i(pwdata_i[ACR_IN_VOL +: 5]),
        .mute_i(pwdata_i[ACR_IN_LMUTE]),
        .commit_i(pwdata_i[ACR_IN_COMMIT]),
        .zc_en_i(pwdata_i[ACR_IN_ZC_EN]),
        .zero_cross_i(adc_zero_cross_i),
        .vol_o(applied_vol),
        .mute_o(applied_mute),
        .pending_o(vol_pending)
    );

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            record_cfg_o <= '0;
        end else begin
            record_cfg_o.record_halve <=
                input_gain_config_reg[ACR_IN_REC_HALVE];
            // Offset store only means something with the high-pass off
            record_cfg_o.dc_hold <= input_gain_config_reg[ACR_IN_HPF_OFF]
                && input_gain_config_reg[ACR_IN_DC_STORE];
            record_cfg_o.dc_clear <=
                !input_gain_config_reg[ACR_IN_DC_STORE];
            record_cfg_o.adc_pol_inv <=
                input_gain_config_reg[ACR_IN_ADC_POL];
            record_cfg_o.dmic_pol_inv <=
                input_gain_config_reg[ACR_IN_DMIC_POL +: 2];
            record_cfg_o.hpf_enable <=
                !input_gain_config_reg[ACR_IN_HPF_OFF];
            record_cfg_o.mic_boost_db <= acr_boost_db(
                input_gain_config_reg[ACR_IN_BOOST +: 2]);
            record_cfg_o.pga_max_db <= 7'($signed({4'h0,
                input_gain_config_reg[ACR_IN_MAXGAIN +: 3]}) * 7'sd6
                - 7'sd30);
            record_cfg_o.analog_mute <=
                input_gain_config_reg[ACR_IN_ANA_MUTE];
            record_cfg_o.record_rate_sel <=
                audio_path_control_reg[ACR_PC_REC_RATE +: 3];
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            playback_cfg_o <= '0;
        end else begin
            playback_cfg_o.playback_halve <=
                input_gain_config_reg[ACR_IN_PLAY_HALVE];
            playback_cfg_o.soft_mute <=
                input_gain_config_reg[ACR_IN_SOFT_MUTE];
            playback_cfg_o.deemph_sel <=
                input_gain_config_reg[ACR_IN_DEEMPH +: 2];
            playback_cfg_o.playback_rate_sel <=
                audio_path_control_reg[ACR_PC_PB_RATE +: 4];
            playback_cfg_o.mclk_22m <= acr_is_22m(
                audio_path_control_reg[ACR_PC_PB_RATE +: 4]);
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            port_cfg_o <= '0;
        end else begin
            // One select bit drives both enables, so they cannot overlap
            port_cfg_o.biphase_en <=
                audio_path_control_reg[ACR_PC_BIPHASE];
            port_cfg_o.serial_en <=
                !audio_path_control_reg[ACR_PC_BIPHASE];
            port_cfg_o.usb_to_serial_port <=
                audio_path_control_reg[ACR_PC_USB_SP];
            port_cfg_o.usb_to_playback <=
                audio_path_control_reg[ACR_PC_USB_PB];
            port_cfg_o.serial_port_source_sel <=
                audio_path_control_reg[ACR_PC_SP_SRC];
            port_cfg_o.playback_source_sel <=
                audio_path_control_reg[ACR_PC_PB_SRC];
            port_cfg_o.bclk_inv <=
                audio_path_control_reg[ACR_PC_BCLK_INV];
            port_cfg_o.clock_master_sel <=
                audio_path_control_reg[ACR_PC_MASTER];
            port_cfg_o.lr_swap <=
                audio_path_control_reg[ACR_PC_LR_SWAP];
            port_cfg_o.lrclk_inv <=
                audio_path_control_reg[ACR_PC_LRCLK_INV];
            port_cfg_o.word_bits <= acr_word_bits(
                audio_path_control_reg[ACR_PC_WLEN +: 2]);
            port_cfg_o.interface_type_field <=
                audio_path_control_reg[ACR_PC_FMT +: 2];
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            input_gain_o <= '0;
        end else begin
            input_gain_o.gain_half_db <=
                acr_vol_half_db(applied_vol);
            input_gain_o.left_mute <= applied_mute;
            input_gain_o.pending <= vol_pending;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            lineout_o <= '0;
        end else begin
            lineout_o.gain_ctrl_en <=
                !lineout_gain_config_reg[ACR_LO_CTRL_DIS];
            lineout_o.lineout_gain_commit <=
                lineout_gain_config_reg[ACR_LO_COMMIT];
            lineout_o.lineout_left_level <=
                lineout_gain_config_reg[ACR_LO_LEFT +: 7];
            lineout_o.lineout_right_level <=
                lineout_gain_config_reg[ACR_LO_RIGHT +: 7];
            // Top bit clear covers every code from 0111111 down
            lineout_o.left_mute <=
                !lineout_gain_config_reg[ACR_LO_LEFT + 6];
            lineout_o.right_mute <=
                !lineout_gain_config_reg[ACR_LO_RIGHT + 6];
        end
    end

    default clocking acr_cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);

    chk_path_write_reset: assert property (
        wr_path |-> ##2 digital_reset_o ##1 !digital_reset_o)
        else $error("path write did not give one reset pulse");

    chk_playback_halve: assert property (
        wr_input |-> ##2 (playback_cfg_o.playback_halve ==
            $past(pwdata_i[ACR_IN_PLAY_HALVE], 2)))
        else $error("playback attenuation does not follow write");

    chk_soft_mute_follow: assert property (
        wr_input |-> ##2 (playback_cfg_o.soft_mute ==
            $past(pwdata_i[ACR_IN_SOFT_MUTE], 2)))
        else $error("soft mute does not follow write");

    chk_serial_exclusive: assert property (
        !(port_cfg_o.biphase_en && port_cfg_o.serial_en))
        else $error("both serial interfaces enabled");

    chk_dc_hold_hpf: assert property (
        record_cfg_o.dc_hold |-> !record_cfg_o.hpf_enable
            && !record_cfg_o.dc_clear)
        else $error("offset held while high-pass active");

    // Judged against the stored code, so the all-zero reset image is legal
    chk_lineout_mute: assert property (
        1'b1 |=> (lineout_o.left_mute ==
            ($past(lineout_gain_config_reg[ACR_LO_LEFT +: 7]) < 7'h40)))
        else $error("left line-out mute mismatch");

    chk_vol_latch_hold: assert property (
        (wr_input && !pwdata_i[ACR_IN_COMMIT] && !vol_pending
            && !adc_zero_cross_i) |=> $stable(applied_vol))
        else $error("latched volume changed gain without commit");

    chk_vol_immediate: assert property (
        (wr_input && pwdata_i[ACR_IN_COMMIT] && !pwdata_i[ACR_IN_ZC_EN])
            |-> ##2 (input_gain_o.gain_half_db ==
            acr_vol_half_db($past(pwdata_i[ACR_IN_VOL +: 5], 2))))
        else $error("immediate volume not applied in two cycles");

    chk_vol_zc_wait: assert property (
        (vol_pending && !adc_zero_cross_i && !wr_input)
            |=> $stable(applied_vol) && vol_pending)
        else $error("volume applied before zero crossing");

    chk_pga_max_range: assert property (
        (record_cfg_o.pga_max_db <= 7'sd12)
            && (record_cfg_o.pga_max_db >= -7'sd30))
        else $error("maximum gain out of range");

    chk_word_bits: assert property (
        wr_path |-> ##2 (port_cfg_o.word_bits ==
            acr_word_bits($past(pwdata_i[ACR_PC_WLEN +: 2], 2))))
        else $error("word length does not follow write");

    cov_zc_commit: cover property (
        vol_pending && adc_zero_cross_i ##1 !vol_pending);
    cov_path_write: cover property (wr_path ##2 digital_reset_o);
    cov_biphase_on: cover property (port_cfg_o.biphase_en);
    cov_unmapped: cover property (pslverr_o);
endmodule // acr_regs
`default_nettype wire

// ---- acr_regs_tb.sv ----
// Self-checking testbench for the audio control register bank
`timescale 1ns/1ns
`default_nettype none
module acr_regs_tb;
    import acr_pkg::*;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [ACR_ADDR_W-1:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0;
    logic adc_zero_cross_i = 1'b0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, digital_reset_o;
    acr_record_type record_cfg_o;
    acr_playback_type playback_cfg_o;
    acr_port_type port_cfg_o;
    acr_input_gain_type input_gain_o;
    acr_lineout_type lineout_o;
    int error_cnt = 0;
    int num_checks = 0;
    logic [31:0] rd;
    logic err;

    acr_regs dut (
        .core_clk_i(core_clk_i), .reset_i(reset_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o),
        .adc_zero_cross_i(adc_zero_cross_i),
        .record_cfg_o(record_cfg_o), .playback_cfg_o(playback_cfg_o),
        .port_cfg_o(port_cfg_o), .input_gain_o(input_gain_o),
        .lineout_o(lineout_o), .digital_reset_o(digital_reset_o)
    );

    always #50 core_clk_i = ~core_clk_i;

    task automatic chk(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // Zero-wait APB transfer; answer is taken while the access phase stands
    task automatic apb(input logic wr, input logic [ACR_ADDR_W-1:0] a,
                       input logic [31:0] d);
        @(posedge core_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        #1;
        rd = prdata_o;
        err = pslverr_o;
        chk("pready", pready_o, 1);
        @(posedge core_clk_i);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    // Register takes the access edge, decoded outputs the edge after it
    task automatic settle;
        @(posedge core_clk_i);
        #1;
    endtask

    task automatic test_reset;
        logic [ACR_ADDR_W-1:0] ofs [3] = '{ACR_OFS_INPUT, ACR_OFS_LINEOUT,
                                           ACR_OFS_PATH};
        logic [31:0] rst [3] = '{ACR_RST_INPUT, ACR_RST_LINEOUT, ACR_RST_PATH};
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, ofs[i], 32'h0);
            chk("reset value", rd, rst[i]);
        end
        chk("soft_mute", playback_cfg_o.soft_mute, 1);
        chk("hpf_enable", record_cfg_o.hpf_enable, 1);
        chk("pga_max", 32'($signed(record_cfg_o.pga_max_db)), 12);
        chk("word_bits", port_cfg_o.word_bits, 24);
        chk("format", port_cfg_o.interface_type_field, 2);
        chk("serial_en", port_cfg_o.serial_en, 1);
        $display("test_reset done");
    endtask

    task automatic test_unmapped;
        apb(1'b0, 12'h00C, 32'h0);
        chk("unmapped err", err, 1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b1, 12'h00C, 32'hFFFFFFFF);
        chk("unmapped wr err", err, 1);
        apb(1'b0, ACR_OFS_PATH, 32'h0);
        chk("path untouched", rd, ACR_RST_PATH);
        chk("no pulse", digital_reset_o, 0);
        $display("test_unmapped done");
    endtask

    task automatic test_path;
        logic [31:0] d;
        logic [3:0] pb [4] = '{4'hB, 4'h3, 4'hA, 4'h0};
        logic [2:0] rr [4] = '{3'h0, 3'h1, 3'h2, 3'h6};
        int wb [4] = '{16, 20, 24, 32};
        for (int i = 0; i < 4; i++) begin
            d = {i[0], i[1], !i[0], 2'h0, rr[i], 8'h0, pb[i], 2'h0, i[0],
                 i[1], i[0], i[1], !i[1], i[1], i[1:0], i[1:0]};
            apb(1'b1, ACR_OFS_PATH, d);
            settle();
            chk("digital_reset", digital_reset_o, 1);
            chk("biphase", port_cfg_o.biphase_en, i[0]);
            chk("serial_en", port_cfg_o.serial_en, !i[0]);
            chk("usb_sp", port_cfg_o.usb_to_serial_port, i[1]);
            chk("usb_pb", port_cfg_o.usb_to_playback, !i[0]);
            chk("sp_src", port_cfg_o.serial_port_source_sel, i[0]);
            chk("pb_src", port_cfg_o.playback_source_sel, i[1]);
            chk("rec_rate", record_cfg_o.record_rate_sel, rr[i]);
            chk("pb_rate", playback_cfg_o.playback_rate_sel, pb[i]);
            chk("mclk_22m", playback_cfg_o.mclk_22m, !i[0]);
            chk("bclk_inv", port_cfg_o.bclk_inv, i[0]);
            chk("master", port_cfg_o.clock_master_sel, i[1]);
            chk("lr_swap", port_cfg_o.lr_swap, !i[1]);
            chk("lrclk_inv", port_cfg_o.lrclk_inv, i[1]);
            chk("word_bits", port_cfg_o.word_bits, wb[i]);
            chk("format", port_cfg_o.interface_type_field, i[1:0]);
            @(posedge core_clk_i);
            #1;
            chk("pulse end", digital_reset_o, 0);
            apb(1'b0, ACR_OFS_PATH, 32'h0);
            chk("path readback", rd, d);
        end
        $display("test_path done");
    endtask

    task automatic test_input;
        logic [31:0] d;
        int bst [4] = '{0, 13, 20, 29};
        logic [2:0] mg [4] = '{3'h0, 3'h3, 3'h5, 3'h7};
        int mdb [4] = '{-30, -12, 0, 12};
        logic [4:0] vol [4] = '{5'h1F, 5'h17, 5'h00, 5'h10};
        int gn [4] = '{24, 0, -69, -21};
        for (int i = 0; i < 4; i++) begin
            d = {i[0], !i[0], i[1:0], i[1], 1'b0, i[0], 2'h0, i[0], i[1:0],
                 2'h0, i[1], 3'h0, i[1:0], 1'b0, mg[i], 1'b1, i[1], 1'b0,
                 vol[i]};
            apb(1'b1, ACR_OFS_INPUT, d);
            settle();
            chk("pb_halve", playback_cfg_o.playback_halve, i[0]);
            chk("rec_halve", record_cfg_o.record_halve, i[1]);
            chk("soft_mute", playback_cfg_o.soft_mute, !i[0]);
            chk("deemph", playback_cfg_o.deemph_sel, i[1:0]);
            chk("dc_hold", record_cfg_o.dc_hold, i[1] & i[0]);
            chk("dc_clear", record_cfg_o.dc_clear, !i[0]);
            chk("adc_pol", record_cfg_o.adc_pol_inv, i[0]);
            chk("dmic_pol", record_cfg_o.dmic_pol_inv, i[1:0]);
            chk("hpf", record_cfg_o.hpf_enable, !i[1]);
            chk("boost", record_cfg_o.mic_boost_db, bst[i]);
            chk("pga", 32'($signed(record_cfg_o.pga_max_db)), mdb[i]);
            chk("gain", 32'($signed(input_gain_o.gain_half_db)), gn[i]);
            chk("left_mute", input_gain_o.left_mute, i[1]);
            chk("pending", input_gain_o.pending, 0);
            apb(1'b0, ACR_OFS_INPUT, 32'h0);
            chk("input readback", rd, d);
        end
        $display("test_input done");
    endtask

    task automatic test_zero_cross;
        apb(1'b1, ACR_OFS_INPUT, 32'h00000000);
        settle();
        chk("staged only", 32'($signed(input_gain_o.gain_half_db)), -21);
        apb(1'b1, ACR_OFS_INPUT, 32'h000000BF);
        settle();
        chk("pending", input_gain_o.pending, 1);
        chk("held gain", 32'($signed(input_gain_o.gain_half_db)), -21);
        @(posedge core_clk_i);
        adc_zero_cross_i <= 1'b1;
        @(posedge core_clk_i);
        adc_zero_cross_i <= 1'b0;
        settle();
        chk("zc gain", 32'($signed(input_gain_o.gain_half_db)), 24);
        chk("zc pending", input_gain_o.pending, 0);
        $display("test_zero_cross done");
    endtask

    task automatic test_lineout;
        logic [31:0] d;
        logic [6:0] r [2] = '{7'h7F, 7'h40};
        logic [6:0] l [2] = '{7'h3F, 7'h30};
        for (int i = 0; i < 2; i++) begin
            d = {16'h0, 1'b0, 1'b1, r[i], l[i]};
            apb(1'b1, ACR_OFS_LINEOUT, d);
            settle();
            chk("lo_ctrl_en", lineout_o.gain_ctrl_en, 1);
            chk("lo_commit", lineout_o.lineout_gain_commit, 1);
            chk("lo_left", lineout_o.lineout_left_level, l[i]);
            chk("lo_right", lineout_o.lineout_right_level, r[i]);
            chk("lo_lmute", lineout_o.left_mute, l[i] < 7'h40);
            chk("lo_rmute", lineout_o.right_mute, r[i] < 7'h40);
            chk("no pulse", digital_reset_o, 0);
            apb(1'b0, ACR_OFS_LINEOUT, 32'h0);
            chk("lineout readback", rd, d);
        end
        $display("test_lineout done");
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    initial begin
        #200000;
        error_cnt++;
        summarize();
    end

    initial begin
        repeat (5) @(posedge core_clk_i);
        reset_i <= 1'b0;
        test_reset();
        test_unmapped();
        test_path();
        test_input();
        test_zero_cross();
        test_lineout();
        summarize();
    end
endmodule // acr_regs_tb
`default_nettype wire
